// ### verilog/sss_params.svh
// timing counts and pin reset values
// assumes a single 10 MHz clock; included by the package and the modules
`ifndef SSS_PARAMS_SVH
`define SSS_PARAMS_SVH

// ----------------------------------------
// clock
// ----------------------------------------
`define SSS_CLK_PERIOD_NS 100
`define SSS_CLK_KHZ 10000

// ----------------------------------------
// reset hold: 140 ms minimum
// ----------------------------------------
`define SSS_HOLD_TIME_MS 140
`define SSS_HOLD_CYC (`SSS_HOLD_TIME_MS * `SSS_CLK_KHZ)
`define SSS_HOLD_CNT_W 21

// ----------------------------------------
// watchdog timeout, typical figure
// ----------------------------------------
`define SSS_WD_PERIOD_MS 1650
`define SSS_WD_CYC (`SSS_WD_PERIOD_MS * `SSS_CLK_KHZ)
`define SSS_WD_CNT_W 24

// ----------------------------------------
// chip-enable access completion window
// ----------------------------------------
`define SSS_CE_FINISH_NS 1000
`define SSS_CE_FINISH_CYC ((`SSS_CE_FINISH_NS + `SSS_CLK_PERIOD_NS - 1) / `SSS_CLK_PERIOD_NS)
`define SSS_CE_CNT_W 4

// ----------------------------------------
// pin synchroniser: width and value held during reset
// bits follow sss_pins_type, supply_low in bit 7
// ----------------------------------------
`define SSS_PIN_W 8
`define SSS_PINS_RESET 8'h9D

`endif

// ### verilog/sss_pkg.sv
// types shared by the supervisor modules
// assumes sss_params.svh on the include path
`include "sss_params.svh"

package sss_pkg;

    // ----------------------------------------
    // pin bundle, one bit per comparator or logic pin
    // ----------------------------------------
    typedef struct packed {
        logic supply_low;
        logic backup_over_hyst;
        logic supply_over_backup;
        logic manual_reset_n;
        logic aux_reset_sense;
        logic supply_fail_sense;
        logic watchdog_kick;
        logic gated_enable_in;
    } sss_pins_type;

    typedef enum logic [2:0] {
        SSS_RST_ASSERT = 3'h1,
        SSS_RST_HOLD = 3'h2,
        SSS_RST_RUN = 3'h4
    } sss_rst_state_type;

    typedef enum logic [2:0] {
        SSS_CE_PASS = 3'h1,
        SSS_CE_FINISH = 3'h2,
        SSS_CE_BLOCK = 3'h4
    } sss_ce_state_type;

    // ----------------------------------------
    // per-module state records
    // ----------------------------------------
    typedef struct packed {
        logic [`SSS_PIN_W-1:0] s1;
        logic [`SSS_PIN_W-1:0] s2;
        logic [`SSS_PIN_W-1:0] s3;
        logic [`SSS_PIN_W-1:0] clean;
    } sss_sync_state_type;

    typedef struct packed {
        logic last_kick;
        logic [`SSS_WD_CNT_W-1:0] cnt;
        logic expire;
    } sss_wd_state_type;

    typedef struct packed {
        sss_rst_state_type rst_state;
        logic [`SSS_HOLD_CNT_W-1:0] hold_cnt;
        sss_ce_state_type ce_state;
        logic [`SSS_CE_CNT_W-1:0] ce_cnt;
        logic reset_n;
        logic flag_n;
        logic backup_sel;
        logic gate_out;
    } sss_main_state_type;

    // terminal count test shared by all timers
    function automatic logic sss_count_done(input logic [31:0] count, input int unsigned limit);
        return count == (limit - 1);
    endfunction : sss_count_done

endpackage : sss_pkg

// ### verilog/sss_pin_sync.sv
// three-stage synchroniser with agreement filter for all supervisor pins
// assumes pins are asynchronous to clock; output changes once stages 2 and 3 agree
`timescale 1ns/1ps
`include "sss_params.svh"

module sss_pin_sync (
    input wire logic clock,
    input wire logic resetn,
    input wire logic clk_en,
    input sss_pkg::sss_pins_type pins_raw,
    output sss_pkg::sss_pins_type pins_clean
);
    import sss_pkg::*;

    sss_sync_state_type st_reg;
    sss_sync_state_type st_next;
    logic [`SSS_PIN_W-1:0] agree;

    // shift chain; stage 1 feeds stage 2 only
    always_comb begin
        st_next = st_reg;
        st_next.s1 = pins_raw;
        st_next.s2 = st_reg.s1;
        st_next.s3 = st_reg.s2;
        agree = ~(st_reg.s2 ^ st_reg.s3);
        st_next.clean = (agree & st_reg.s3) | (~agree & st_reg.clean);
    end

    // frozen while clk_en is low
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            st_reg <= {4{`SSS_PINS_RESET}};
        end else if (clk_en) begin
            st_reg <= st_next;
        end
    end

    assign pins_clean = sss_pins_type'(st_reg.clean);

endmodule : sss_pin_sync

// ### verilog/sss_watchdog.sv
// watchdog timer: counts while the kick input stands still
// assumes kick is already synchronised and clear is the registered reset state
`timescale 1ns/1ps
`include "sss_params.svh"

module sss_watchdog #(
    parameter int unsigned PERIOD_CYCLES = `SSS_WD_CYC
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic clk_en,
    input wire logic kick,
    input wire logic clear,
    output logic expire
);
    import sss_pkg::*;

    sss_wd_state_type st_reg;
    sss_wd_state_type st_next;

    // either kick edge or an asserted reset restarts the count
    always_comb begin
        st_next = st_reg;
        st_next.last_kick = kick;
        st_next.expire = 1'b0;
        if (clear || (kick != st_reg.last_kick)) begin // (R6)
            st_next.cnt = '0;
        end else if (sss_count_done(32'(st_reg.cnt), PERIOD_CYCLES)) begin // (R5)
            st_next.cnt = '0;
            st_next.expire = 1'b1;
        end else begin
            st_next.cnt = st_reg.cnt + 1'b1;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            st_reg <= '0;
        end else if (clk_en) begin
            st_reg <= st_next;
        end
    end

    assign expire = st_reg.expire;

endmodule : sss_watchdog

// ### verilog/sss_supervisor.sv
// supply supervisor reset logic: reset combiner, hold timer, watchdog,
// power-fail flag, backup switchover select and chip-enable gating
// assumes comparator results arrive as levels asynchronous to clock
//
// Contract
// (R1) reset stays low while supply low, manual reset low or aux sense low
// (R2) reset held low a full hold time after every release event
// (R3) hold time after manual reset release is at least 140 ms
// (R4) watchdog expiry asserts reset as a pulse, repeating while expiry repeats
// (R5) kick input stuck past the timeout expires the watchdog, giving hold-length pulse
// (R6) watchdog timer clears on asserted reset and on either kick edge
// (R7) processor toggles the kick input faster than once per timeout period
// (R8) aux sense below its threshold asserts reset, held until hold time after rising
// (R9) power-fail flag low while power-fail sense is below its threshold
// (R10) power-fail flag also forced low while the supply is below threshold
// (R11) switched output fed from supply normally, from greater source when supply low
// (R12) switch to battery only above 40 mV margin, back once supply exceeds it
// (R13) backup-active indicator high in battery backup mode, low otherwise
// (R14) gated enable output low only when input low and reset not asserted
// (R15) gated enable output driven high whenever decoupled from its input
// (R16) access in flight at reset gets 1 us low, then output forced high
// (R17) system ties unused gated enable input to a fixed level
// (R18) hold timer restarts on any reappearing condition; release needs one clean interval
`timescale 1ns/1ps
`include "sss_params.svh"

module sss_supervisor #(
    parameter int unsigned HOLD_CYCLES = `SSS_HOLD_CYC,
    parameter int unsigned WD_CYCLES = `SSS_WD_CYC,
    parameter int unsigned CE_FINISH_CYCLES = `SSS_CE_FINISH_CYC
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic clk_en,
    input wire logic supply_low,
    input wire logic backup_over_hyst,
    input wire logic supply_over_backup,
    input wire logic manual_reset_n,
    input wire logic aux_reset_sense,
    input wire logic supply_fail_sense,
    input wire logic watchdog_kick,
    input wire logic gated_enable_in,
    output logic system_reset_n,
    output logic supply_fail_flag_n,
    output logic backup_active,
    output logic gated_enable_out
);
    import sss_pkg::*;

    // ----------------------------------------
    // declarations
    // ----------------------------------------
    sss_main_state_type st_reg;
    sss_main_state_type st_next;
    sss_pins_type pins_raw;
    sss_pins_type pins;
    logic wd_expire;
    logic reset_cond;
    logic reset_clear;
    logic hold_done;
    logic ce_done;

    // reset value of the whole state record; reset comes up asserted
    localparam sss_main_state_type MAIN_RESET = '{
        rst_state: SSS_RST_ASSERT,
        hold_cnt: '0,
        ce_state: SSS_CE_BLOCK,
        ce_cnt: '0,
        reset_n: 1'b0,
        flag_n: 1'b0,
        backup_sel: 1'b0,
        gate_out: 1'b1
    };

    // ----------------------------------------
    // pin capture
    // ----------------------------------------

    // bundle the pins for the synchroniser
    always_comb begin
        pins_raw.supply_low = supply_low;
        pins_raw.backup_over_hyst = backup_over_hyst;
        pins_raw.supply_over_backup = supply_over_backup;
        pins_raw.manual_reset_n = manual_reset_n;
        pins_raw.aux_reset_sense = aux_reset_sense;
        pins_raw.supply_fail_sense = supply_fail_sense;
        pins_raw.watchdog_kick = watchdog_kick;
        pins_raw.gated_enable_in = gated_enable_in;
    end

    // every pin pays the same four-cycle latency, so relative order holds
    sss_pin_sync u_sync (
        .clock(clock),
        .resetn(resetn),
        .clk_en(clk_en),
        .pins_raw(pins_raw),
        .pins_clean(pins)
    );

    // ----------------------------------------
    // watchdog
    // ----------------------------------------

    // cleared by the registered reset, so a pulse also re-arms it
    assign reset_clear = !st_reg.reset_n;

    sss_watchdog #(
        .PERIOD_CYCLES(WD_CYCLES)
    ) u_wdog (
        .clock(clock),
        .resetn(resetn),
        .clk_en(clk_en),
        .kick(pins.watchdog_kick),
        .clear(reset_clear), // (R6)
        .expire(wd_expire)
    );

    // ----------------------------------------
    // reset sources and terminal counts
    // ----------------------------------------

    // level sources; supply_low alone covers backup mode
    assign reset_cond = pins.supply_low | !pins.manual_reset_n | !pins.aux_reset_sense; // (R1) (R8)

    // one shared compare for both timers
    assign hold_done = sss_count_done(32'(st_reg.hold_cnt), HOLD_CYCLES); // (R3)
    assign ce_done = sss_count_done(32'(st_reg.ce_cnt), CE_FINISH_CYCLES); // (R16)

    // ----------------------------------------
    // next-state logic
    // ----------------------------------------

    // one pass over the whole state record
    always_comb begin
        st_next = st_reg;

        // reset sequencer: assert while a source is active, then hold
        case (st_reg.rst_state)
            SSS_RST_ASSERT: begin
                st_next.hold_cnt = '0;
                if (!reset_cond) begin // (R2)
                    st_next.rst_state = SSS_RST_HOLD;
                end
            end
            SSS_RST_HOLD: begin
                if (reset_cond) begin // (R18)
                    st_next.rst_state = SSS_RST_ASSERT;
                    st_next.hold_cnt = '0;
                end else if (hold_done) begin // (R2) (R3)
                    st_next.rst_state = SSS_RST_RUN;
                    st_next.hold_cnt = '0;
                end else begin
                    st_next.hold_cnt = st_reg.hold_cnt + 1'b1;
                end
            end
            SSS_RST_RUN: begin
                st_next.hold_cnt = '0;
                if (reset_cond) begin // (R1)
                    st_next.rst_state = SSS_RST_ASSERT;
                end else if (wd_expire) begin // (R4) (R5)
                    // a watchdog event is a pulse: straight into hold
                    st_next.rst_state = SSS_RST_HOLD;
                end
            end
            default: begin
                st_next.rst_state = SSS_RST_ASSERT;
                st_next.hold_cnt = '0;
            end
        endcase

        // reset output is high only in the run state
        st_next.reset_n = (st_next.rst_state == SSS_RST_RUN); // (R1) (R2)

        // power-fail flag; supply low forces it
        st_next.flag_n = pins.supply_fail_sense && !pins.supply_low; // (R9) (R10)

        // switchover with hysteresis; the 40 mV margin lives in the comparator
        if (!pins.supply_low) begin // (R11)
            st_next.backup_sel = 1'b0;
        end else if (!st_reg.backup_sel && pins.backup_over_hyst) begin // (R12)
            st_next.backup_sel = 1'b1;
        end else if (st_reg.backup_sel && pins.supply_over_backup) begin // (R12)
            st_next.backup_sel = 1'b0;
        end

        // chip-enable gate keyed to the next reset_n, so both move on one edge
        case (st_reg.ce_state)
            SSS_CE_PASS: begin
                st_next.ce_cnt = '0;
                if (st_next.reset_n) begin // (R14)
                    st_next.gate_out = pins.gated_enable_in;
                end else if (!pins.gated_enable_in) begin // (R16)
                    st_next.ce_state = SSS_CE_FINISH;
                    st_next.gate_out = 1'b0;
                end else begin // (R15)
                    st_next.ce_state = SSS_CE_BLOCK;
                    st_next.gate_out = 1'b1;
                end
            end
            SSS_CE_FINISH: begin
                // input ignored during the completion window
                st_next.gate_out = 1'b0;
                if (ce_done) begin // (R16)
                    st_next.ce_state = SSS_CE_BLOCK;
                    st_next.gate_out = 1'b1;
                    st_next.ce_cnt = '0;
                end else begin
                    st_next.ce_cnt = st_reg.ce_cnt + 1'b1;
                end
            end
            SSS_CE_BLOCK: begin
                st_next.ce_cnt = '0;
                st_next.gate_out = 1'b1; // (R15)
                if (st_next.reset_n) begin // (R14)
                    st_next.ce_state = SSS_CE_PASS;
                    st_next.gate_out = pins.gated_enable_in;
                end
            end
            default: begin
                st_next.ce_state = SSS_CE_BLOCK;
                st_next.ce_cnt = '0;
                st_next.gate_out = 1'b1;
            end
        endcase
    end

    // ----------------------------------------
    // state register
    // ----------------------------------------

    // low clk_en freezes every timer and output
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            st_reg <= MAIN_RESET;
        end else if (clk_en) begin
            st_reg <= st_next;
        end
    end

    // ----------------------------------------
    // outputs, all straight from flip-flops
    // ----------------------------------------

    // hold outlasts the access window, so finish never meets a release
    assign system_reset_n = st_reg.reset_n;
    assign supply_fail_flag_n = st_reg.flag_n;
    // one select drives the source switch and the indicator
    assign backup_active = st_reg.backup_sel; // (R13)
    // clocked stand-in for the transmission gate, a few cycles late
    assign gated_enable_out = st_reg.gate_out;

endmodule : sss_supervisor

// ### dv/sss_supervisor_asserts.sv
// pin-level timing checks for the supply supervisor
// assumes binding into sss_supervisor; no checks while clk_en is low
`timescale 1ns/1ps

module sss_supervisor_asserts #(
    parameter int unsigned HOLD_CYCLES = 20,
    parameter int unsigned WD_CYCLES = 50,
    parameter int unsigned CE_FINISH_CYCLES = 10
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic clk_en,
    input wire logic supply_low,
    input wire logic backup_over_hyst,
    input wire logic supply_over_backup,
    input wire logic manual_reset_n,
    input wire logic aux_reset_sense,
    input wire logic supply_fail_sense,
    input wire logic watchdog_kick,
    input wire logic gated_enable_in,
    input wire logic system_reset_n,
    input wire logic supply_fail_flag_n,
    input wire logic backup_active,
    input wire logic gated_enable_out
);
    // ----------------------------------------
    // helper counters
    // ----------------------------------------
    logic [31:0] low_cnt_reg;
    logic [31:0] quiet_cnt_reg;
    logic [31:0] wd_cnt_reg;
    logic [31:0] ce_cnt_reg;
    logic last_kick_reg;
    logic cond;
    assign cond = supply_low | ~manual_reset_n | ~aux_reset_sense;

    // condition and kick counters measure from raw pins, so bounds allow for synchroniser lag
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            low_cnt_reg <= 32'h0;
            quiet_cnt_reg <= 32'h0;
            wd_cnt_reg <= 32'h0;
            ce_cnt_reg <= 32'h0;
            last_kick_reg <= 1'b0;
        end else begin
            low_cnt_reg <= system_reset_n ? 32'h0 : low_cnt_reg + 32'h1;
            quiet_cnt_reg <= cond ? 32'h0 : quiet_cnt_reg + 32'h1;
            wd_cnt_reg <= (!system_reset_n || watchdog_kick != last_kick_reg) ? 32'h0 : wd_cnt_reg + 32'h1;
            ce_cnt_reg <= (system_reset_n || gated_enable_out) ? 32'h0 : ce_cnt_reg + 32'h1;
            last_kick_reg <= watchdog_kick;
        end
    end

    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking dc @(posedge clock); endclocking
    default disable iff (!resetn || !clk_en);
    sequence cond_held_s;
        cond [*8];
    endsequence
    sequence reset_rise_s;
        $rose(system_reset_n);
    endsequence

    reset_on_cond_a: assert property (cond_held_s |-> !system_reset_n)
        else $error("reset high while a reset condition stands");
    hold_length_a: assert property (reset_rise_s |-> low_cnt_reg >= HOLD_CYCLES)
        else $error("reset pulse shorter than the hold time");
    hold_restart_a: assert property (reset_rise_s |-> quiet_cnt_reg >= HOLD_CYCLES)
        else $error("reset released without a clean hold interval");
    wd_late_a: assert property (wd_cnt_reg <= WD_CYCLES + 12)
        else $error("watchdog failed to expire on a still kick");
    wd_early_a: assert property ($fell(system_reset_n) && quiet_cnt_reg > 8 |-> wd_cnt_reg + 4 >= WD_CYCLES)
        else $error("watchdog reset came too early");
    flag_low_a: assert property ((!supply_fail_sense || supply_low) [*8] |-> !supply_fail_flag_n)
        else $error("power-fail flag not low");
    flag_high_a: assert property ((supply_fail_sense && !supply_low) [*8] |-> supply_fail_flag_n)
        else $error("power-fail flag not high");
    backup_off_a: assert property ((!supply_low) [*8] |-> !backup_active)
        else $error("backup active with supply good");
    backup_on_a: assert property ((supply_low && backup_over_hyst && !supply_over_backup) [*8] |-> backup_active)
        else $error("backup not selected");
    backup_back_a: assert property (supply_over_backup [*8] |-> !backup_active)
        else $error("backup kept with supply above battery");
    gate_block_a: assert property (gated_enable_in [*8] |-> gated_enable_out)
        else $error("gated enable low with input high");
    gate_pass_a: assert property ((system_reset_n && !gated_enable_in) [*8] |-> !gated_enable_out)
        else $error("gated enable not passed");
    gate_high_rst_a: assert property (!system_reset_n && gated_enable_out |=> gated_enable_out || system_reset_n)
        else $error("gated enable dropped during reset");
    gate_finish_a: assert property (ce_cnt_reg <= CE_FINISH_CYCLES)
        else $error("gated enable low too long in reset");
endmodule : sss_supervisor_asserts

bind sss_supervisor sss_supervisor_asserts #(.HOLD_CYCLES(HOLD_CYCLES), .WD_CYCLES(WD_CYCLES),
    .CE_FINISH_CYCLES(CE_FINISH_CYCLES)) chk (.clock(clock), .resetn(resetn), .clk_en(clk_en),
    .supply_low(supply_low), .backup_over_hyst(backup_over_hyst), .supply_over_backup(supply_over_backup),
    .manual_reset_n(manual_reset_n), .aux_reset_sense(aux_reset_sense), .supply_fail_sense(supply_fail_sense),
    .watchdog_kick(watchdog_kick), .gated_enable_in(gated_enable_in), .system_reset_n(system_reset_n),
    .supply_fail_flag_n(supply_fail_flag_n), .backup_active(backup_active), .gated_enable_out(gated_enable_out));

// ### dv/sss_cpu_model.sv
// processor and memory-access model on the far side of the supervisor
// assumes the bench gates kicking and requests accesses; drives at falling edge
`timescale 1ns/1ps

module sss_cpu_model #(
    parameter int unsigned KICK_GAP = 10
) (
    input wire logic clock,
    input wire logic kick_en,
    input wire logic access_req,
    output logic watchdog_kick,
    output logic gated_enable_in
);
    int unsigned gap;

    // ----------------------------------------
    // kick and chip-enable drive
    // ----------------------------------------
    initial begin
        watchdog_kick = 1'b0;
        gated_enable_in = 1'b1;
        gap = 0;
    end
    // kick well inside the timeout; enable always at a firm level
    always @(negedge clock) begin
        gated_enable_in <= !access_req;
        if (kick_en) begin
            gap = (gap + 1) % KICK_GAP;
            if (gap == 0) begin
                watchdog_kick <= !watchdog_kick;
            end
        end
    end
endmodule : sss_cpu_model

// ### dv/tb_top.sv
// self-checking bench for the supervisor with short hold and watchdog counts
// assumes the checker is bound in; the bench drives inputs at falling edge
`timescale 1ns/1ps

module tb_top;
    localparam int unsigned HOLD = 20;
    localparam int unsigned WD = 50;
    localparam int unsigned CEF = 10;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic clk_en = 1'b1;
    logic supply_low = 1'b0;
    logic backup_over_hyst = 1'b0;
    logic supply_over_backup = 1'b0;
    logic manual_reset_n = 1'b1;
    logic aux_reset_sense = 1'b1;
    logic supply_fail_sense = 1'b1;
    logic kick_en = 1'b1;
    logic access_req = 1'b0;
    logic watchdog_kick;
    logic gated_enable_in;
    logic system_reset_n;
    logic supply_fail_flag_n;
    logic backup_active;
    logic gated_enable_out;
    int mismatches = 0;
    int n_compared = 0;
    int c;

    sss_supervisor #(.HOLD_CYCLES(HOLD), .WD_CYCLES(WD), .CE_FINISH_CYCLES(CEF)) uut (.clock(clock),
        .resetn(resetn), .clk_en(clk_en), .supply_low(supply_low), .backup_over_hyst(backup_over_hyst),
        .supply_over_backup(supply_over_backup), .manual_reset_n(manual_reset_n),
        .aux_reset_sense(aux_reset_sense), .supply_fail_sense(supply_fail_sense),
        .watchdog_kick(watchdog_kick), .gated_enable_in(gated_enable_in), .system_reset_n(system_reset_n),
        .supply_fail_flag_n(supply_fail_flag_n), .backup_active(backup_active),
        .gated_enable_out(gated_enable_out));
    sss_cpu_model #(.KICK_GAP(10)) cpu (.clock(clock), .kick_en(kick_en), .access_req(access_req),
        .watchdog_kick(watchdog_kick), .gated_enable_in(gated_enable_in));

    initial begin
        forever #50 clock = ~clock;
    end

    // ----------------------------------------
    // compare, wait and verdict
    // ----------------------------------------
    task automatic print_verdict();
        $display("compared=%0d mismatches=%0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : print_verdict
    task automatic check_eq(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check_eq
    task automatic check_range(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
        n_compared++;
        if ((got >= lo && got <= hi) !== 1'b1) begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h lo=%h", $time, got, lo);
        end
    endtask : check_range
    // bounded wait for a reset level, counted in cycles
    task automatic wait_rst(input logic lvl, input int max, output int cyc);
        cyc = 0;
        while (system_reset_n !== lvl) begin
            if (cyc >= max) begin
                mismatches++;
                $display("MISMATCH t=%0t got=%h exp=%h", $time, system_reset_n, lvl);
                print_verdict();
            end
            @(negedge clock);
            cyc++;
        end
    endtask : wait_rst
    // allow for synchroniser latency
    task automatic settle();
        repeat (10) @(negedge clock);
    endtask : settle
    task automatic cond_set(input int src, input logic v);
        case (src)
            0: manual_reset_n = !v;
            1: aux_reset_sense = !v;
            default: supply_low = v;
        endcase
    endtask : cond_set

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_powerup();
        wait_rst(1'b1, HOLD + 40, c);
        check_eq(supply_fail_flag_n, 1);
        check_eq(backup_active, 0);
        check_eq(gated_enable_out, 1);
    endtask : t_powerup
    // condition, release, reappear mid-hold, then time the final release
    task automatic t_cond(input int src);
        cond_set(src, 1'b1);
        settle();
        check_eq(system_reset_n, 0);
        check_eq(supply_fail_flag_n, src == 2 ? 0 : 1);
        cond_set(src, 1'b0);
        repeat (8) @(negedge clock);
        cond_set(src, 1'b1);
        repeat (4) @(negedge clock);
        cond_set(src, 1'b0);
        wait_rst(1'b1, HOLD + 40, c);
        check_range(c, HOLD + 1, HOLD + 8);
    endtask : t_cond
    task automatic t_flag();
        supply_fail_sense = 1'b0;
        settle();
        check_eq(supply_fail_flag_n, 0);
        supply_fail_sense = 1'b1;
        settle();
        check_eq(supply_fail_flag_n, 1);
    endtask : t_flag
    task automatic t_backup();
        supply_low = 1'b1;
        settle();
        check_eq(backup_active, 0);
        backup_over_hyst = 1'b1;
        settle();
        check_eq(backup_active, 1);
        backup_over_hyst = 1'b0;
        settle();
        check_eq(backup_active, 1);
        supply_over_backup = 1'b1;
        settle();
        check_eq(backup_active, 0);
        supply_over_backup = 1'b0;
        backup_over_hyst = 1'b1;
        settle();
        supply_low = 1'b0;
        settle();
        check_eq(backup_active, 0);
        backup_over_hyst = 1'b0;
        wait_rst(1'b1, HOLD + 40, c);
    endtask : t_backup
    // access in flight at reset gets the finish window only
    task automatic t_gate();
        access_req = 1'b1;
        settle();
        check_eq(gated_enable_out, 0);
        manual_reset_n = 1'b0;
        wait_rst(1'b0, 20, c);
        c = 0;
        while (gated_enable_out !== 1'b1 && c < 30) begin
            @(negedge clock);
            c++;
        end
        check_eq(c, CEF);
        access_req = 1'b0;
        repeat (3) @(negedge clock);
        access_req = 1'b1;
        repeat (6) @(negedge clock);
        check_eq(gated_enable_out, 1);
        manual_reset_n = 1'b1;
        wait_rst(1'b1, HOLD + 40, c);
        settle();
        check_eq(gated_enable_out, 0);
        access_req = 1'b0;
        settle();
        check_eq(gated_enable_out, 1);
    endtask : t_gate
    // still kick gives repeating hold-length pulses; kicking stops them
    task automatic t_watchdog();
        kick_en = 1'b0;
        wait_rst(1'b0, WD + 30, c);
        check_range(c, WD - 6, WD + 12);
        wait_rst(1'b1, HOLD + 10, c);
        check_eq(c, HOLD);
        wait_rst(1'b0, WD + 20, c);
        check_range(c, WD - 2, WD + 6);
        clk_en = 1'b0;
        repeat (3 * HOLD) @(negedge clock);
        check_eq(system_reset_n, 0);
        clk_en = 1'b1;
        wait_rst(1'b1, HOLD + 10, c);
        check_eq(c, HOLD);
        kick_en = 1'b1;
        c = 0;
        repeat (3 * WD) begin
            @(negedge clock);
            if (system_reset_n !== 1'b1) c++;
        end
        check_eq(c, 0);
    endtask : t_watchdog

    initial begin
        repeat (12) @(negedge clock);
        resetn = 1'b1;
        t_powerup();
        t_flag();
        for (int s = 0; s < 3; s++) t_cond(s);
        t_backup();
        t_gate();
        t_watchdog();
        print_verdict();
    end
endmodule : tb_top
